// *** port_ef_alt_pkg.sv ***
// Bit positions, reset values and constants for the port E/F override logic
package port_ef_alt_pkg;

    // Width of each port
    localparam int PORT_W = 8;

    // Port E pin roles
    localparam int PE_CLKO = 7;
    localparam int PE_DO   = 6;
    localparam int PE_SDA  = 5;
    localparam int PE_SCL  = 4;
    localparam int PE_AIN1 = 3;
    localparam int PE_XCK  = 2;
    localparam int PE_TXD  = 1;
    localparam int PE_RXD  = 0;

    // Port F pin roles while the test port is enabled
    localparam int PF_TDI = 7;
    localparam int PF_TDO = 6;
    localparam int PF_TMS = 5;
    localparam int PF_TCK = 4;

    // Port F pins taken by the test port
    localparam logic [7:0] PF_JTAG_MASK = 8'hF0;
    // Port F pins that keep their pull-up through reset
    localparam logic [7:0] PF_JTAG_PU_MASK = 8'hB0;

    // Values held during and right after reset
    localparam logic [7:0] RST_DRIVE_N = 8'hFF;
    localparam logic [7:0] RST_OUT     = 8'h00;
    localparam logic [7:0] RST_PULLUP  = 8'h00;
    localparam logic [7:0] RST_DIN     = 8'h00;
    localparam logic       RST_BIT     = 1'b0;

endpackage

// *** port_e_f_alt_function_override.sv ***
// Alternate-function override logic for the port E and port F pins
//
// How it works
// [RULE_01] Clock-output fuse forces top port E pin to drive divided clock.
// [RULE_02] Three-wire serial mode replaces port E bit 6 value with data out.
// [RULE_03] Two-wire data pin: pull-up off, gated direction, value low.
// [RULE_04] Two-wire clock pin: pull-up off, hold direction, low, toggles.
// [RULE_05] Pin-change mask and group enable force input enable, bits 7-4 and 1-0; start detector also on 5-4.
// [RULE_06] Bits 3-2 input enable follows mask and comparator disable bits.
// [RULE_07] USART clock pin works only in synchronous mode, direction picks.
// [RULE_08] Transmitter enable makes bit 1 an output carrying transmit data.
// [RULE_09] Receiver enable forces bit 0 to input, feeding receiver too.
// [RULE_10] Forced receive input gets pull-up from port bit unless disabled.
// [RULE_11] Test port enable keeps TDI, TMS, TCK pull-ups on, even in reset.
// [RULE_12] Test port enable takes port F bits 7-4 from general use.
// [RULE_13] TDO drives only in shift states, else released with pull-up.
// [RULE_14] External tester steps the TAP states with TMS on test clock.
// [RULE_15] TAP work runs on the test clock pin, not the system clock.
// [RULE_16] Outside parties keep port F outputs quiet during conversions.
// [RULE_17] Each enabled override replaces the normal port value.
`timescale 1ns/1ps

module port_e_f_alt_function_override (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_pe_port,
    input  wire logic [7:0] i_pe_dir,
    input  wire logic [7:0] i_pf_port,
    input  wire logic [7:0] i_pf_dir,
    input  wire logic       i_global_pullup_disable,
    input  wire logic       i_sleep_input_disable,
    input  wire logic       i_clock_output_fuse,
    input  wire logic       i_io_clk_div,
    input  wire logic       i_serial_two_wire_mode,
    input  wire logic       i_serial_three_wire_mode,
    input  wire logic       i_serial_data_out,
    input  wire logic       i_serial_clock_hold,
    input  wire logic       i_serial_clock_toggle_strobe,
    input  wire logic       i_start_condition_irq_enable,
    input  wire logic       i_pin_change_group_enable,
    input  wire logic [7:0] i_pin_change_mask,
    input  wire logic       i_comparator_pos_digital_disable,
    input  wire logic       i_comparator_neg_digital_disable,
    input  wire logic       i_usart_sync_mode,
    input  wire logic       i_usart_clock,
    input  wire logic       i_transmitter_enable,
    input  wire logic       i_transmit_data,
    input  wire logic       i_receiver_enable,
    input  wire logic       i_jtag_enable,
    input  wire logic       i_tap_shift_ir,
    input  wire logic       i_tap_shift_dr,
    input  wire logic       i_tap_tdo,
    input  wire logic [7:0] i_pe_pin,
    input  wire logic [7:0] i_pf_pin,
    output logic      [7:0] o_pe_drive_n,
    output logic      [7:0] o_pe_out,
    output logic      [7:0] o_pe_pullup,
    output logic      [7:0] o_pe_din,
    output logic            o_pe_toggle,
    output logic      [7:0] o_pf_drive_n,
    output logic      [7:0] o_pf_out,
    output logic      [7:0] o_pf_pullup,
    output logic      [7:0] o_pf_din,
    output logic            o_receive_data,
    output logic            o_serial_data_in,
    output logic            o_serial_clock_in,
    output logic            o_usart_clock_in,
    output logic            o_jtag_tdi,
    output logic            o_jtag_tms,
    output logic            o_jtag_tck
);

    // Override takes the place of the normal value bit by bit
    function automatic logic [7:0] pick(
        input logic [7:0] en,
        input logic [7:0] val,
        input logic [7:0] norm
    );
        pick = (en & val) | (~en & norm);
    endfunction

    // Pin synchroniser stages
    logic [7:0] pe_meta;
    logic [7:0] pe_sync;
    logic [7:0] pf_meta;
    logic [7:0] pf_sync;

    // Override vectors for port E
    logic [7:0] pe_pu_oe;
    logic [7:0] pe_pu_ov;
    logic [7:0] pe_dd_oe;
    logic [7:0] pe_dd_ov;
    logic [7:0] pe_pv_oe;
    logic [7:0] pe_pv_ov;
    logic [7:0] pe_die_oe;
    logic [7:0] pe_die_ov;

    // Override vectors for port F
    logic [7:0] pf_pu_oe;
    logic [7:0] pf_pu_ov;
    logic [7:0] pf_dd_oe;
    logic [7:0] pf_dd_ov;
    logic [7:0] pf_pv_oe;
    logic [7:0] pf_pv_ov;
    logic [7:0] pf_die_oe;
    logic [7:0] pf_die_ov;

    // Resolved pin controls
    logic [7:0] pe_dir_f;
    logic [7:0] pf_dir_f;
    logic [7:0] pe_die_f;
    logic [7:0] pf_die_f;
    logic [7:0] mask_grp;
    logic       xck_out_en;
    logic       tdo_drive;

    // Next values of the registered outputs
    logic [7:0] next_pe_drive_n;
    logic [7:0] next_pe_out;
    logic [7:0] next_pe_pullup;
    logic [7:0] next_pe_din;
    logic       next_pe_toggle;
    logic [7:0] next_pf_drive_n;
    logic [7:0] next_pf_out;
    logic [7:0] next_pf_pullup;
    logic [7:0] next_pf_din;
    logic       next_receive_data;
    logic       next_serial_data_in;
    logic       next_serial_clock_in;
    logic       next_usart_clock_in;
    logic       next_jtag_tdi;
    logic       next_jtag_tms;
    logic       next_jtag_tck;

    // Two flops on every pad input; only the second stage is read
    always_ff @(posedge i_core_clk) begin
        pe_meta <= i_pe_pin;
        pe_sync <= pe_meta;
        pf_meta <= i_pf_pin;
        pf_sync <= pf_meta;
    end

    // Port E override enables and values
    always_comb begin
        mask_grp   = i_pin_change_mask & {8{i_pin_change_group_enable}};
        xck_out_en = i_usart_sync_mode & i_pe_dir[port_ef_alt_pkg::PE_XCK];
        pe_pu_oe   = 8'h00;
        pe_pu_ov   = 8'h00;
        pe_dd_oe   = 8'h00;
        pe_dd_ov   = 8'h00;
        pe_pv_oe   = 8'h00;
        pe_pv_ov   = 8'h00;
        pe_die_oe  = mask_grp;
        pe_die_ov  = 8'hFF;
        // [RULE_01] divided clock out
        pe_dd_oe[port_ef_alt_pkg::PE_CLKO] = i_clock_output_fuse;
        pe_dd_ov[port_ef_alt_pkg::PE_CLKO] = 1'b1;
        pe_pv_oe[port_ef_alt_pkg::PE_CLKO] = i_clock_output_fuse;
        pe_pv_ov[port_ef_alt_pkg::PE_CLKO] = i_io_clk_div;
        // [RULE_02] three-wire data out
        pe_pv_oe[port_ef_alt_pkg::PE_DO] = i_serial_three_wire_mode;
        pe_pv_ov[port_ef_alt_pkg::PE_DO] = i_serial_data_out;
        // [RULE_03] two-wire data pin
        pe_pu_oe[port_ef_alt_pkg::PE_SDA] = i_serial_two_wire_mode;
        pe_dd_oe[port_ef_alt_pkg::PE_SDA] = i_serial_two_wire_mode;
        pe_dd_ov[port_ef_alt_pkg::PE_SDA] =
            (i_serial_data_out | i_pe_port[port_ef_alt_pkg::PE_SDA])
            & i_pe_dir[port_ef_alt_pkg::PE_SDA];
        pe_pv_oe[port_ef_alt_pkg::PE_SDA] =
            i_serial_two_wire_mode & i_pe_dir[port_ef_alt_pkg::PE_SDA];
        // [RULE_04] two-wire clock pin
        pe_pu_oe[port_ef_alt_pkg::PE_SCL] = i_serial_two_wire_mode;
        pe_dd_oe[port_ef_alt_pkg::PE_SCL] = i_serial_two_wire_mode;
        pe_dd_ov[port_ef_alt_pkg::PE_SCL] =
            (i_serial_clock_hold & i_pe_port[port_ef_alt_pkg::PE_SCL])
            | i_pe_dir[port_ef_alt_pkg::PE_SCL];
        pe_pv_oe[port_ef_alt_pkg::PE_SCL] =
            i_serial_two_wire_mode & i_pe_dir[port_ef_alt_pkg::PE_SCL];
        // [RULE_05] start detector keeps input alive
        pe_die_oe[port_ef_alt_pkg::PE_SDA] =
            mask_grp[port_ef_alt_pkg::PE_SDA] | i_start_condition_irq_enable;
        pe_die_oe[port_ef_alt_pkg::PE_SCL] =
            mask_grp[port_ef_alt_pkg::PE_SCL] | i_start_condition_irq_enable;
        // [RULE_06] comparator pins may disable input
        pe_die_oe[port_ef_alt_pkg::PE_AIN1] =
            mask_grp[port_ef_alt_pkg::PE_AIN1]
            | i_comparator_neg_digital_disable;
        pe_die_ov[port_ef_alt_pkg::PE_AIN1] =
            mask_grp[port_ef_alt_pkg::PE_AIN1];
        pe_die_oe[port_ef_alt_pkg::PE_XCK] =
            mask_grp[port_ef_alt_pkg::PE_XCK]
            | i_comparator_pos_digital_disable;
        pe_die_ov[port_ef_alt_pkg::PE_XCK] =
            mask_grp[port_ef_alt_pkg::PE_XCK];
        // [RULE_07] synchronous USART clock out
        pe_pv_oe[port_ef_alt_pkg::PE_XCK] = xck_out_en;
        pe_pv_ov[port_ef_alt_pkg::PE_XCK] = i_usart_clock;
        // [RULE_08] transmit pin
        pe_pu_oe[port_ef_alt_pkg::PE_TXD] = i_transmitter_enable;
        pe_dd_oe[port_ef_alt_pkg::PE_TXD] = i_transmitter_enable;
        pe_dd_ov[port_ef_alt_pkg::PE_TXD] = 1'b1;
        pe_pv_oe[port_ef_alt_pkg::PE_TXD] = i_transmitter_enable;
        pe_pv_ov[port_ef_alt_pkg::PE_TXD] = i_transmit_data;
        // [RULE_09] receive pin forced to input
        pe_dd_oe[port_ef_alt_pkg::PE_RXD] = i_receiver_enable;
        pe_dd_ov[port_ef_alt_pkg::PE_RXD] = 1'b0;
        // [RULE_10] receive pull-up from port bit
        pe_pu_oe[port_ef_alt_pkg::PE_RXD] = i_receiver_enable;
        pe_pu_ov[port_ef_alt_pkg::PE_RXD] =
            i_pe_port[port_ef_alt_pkg::PE_RXD] & ~i_global_pullup_disable;
    end

    // Port F override enables and values
    always_comb begin
        tdo_drive = i_tap_shift_ir | i_tap_shift_dr;
        // [RULE_12] test port owns the upper nibble
        pf_pu_oe  = i_jtag_enable ? port_ef_alt_pkg::PF_JTAG_MASK : 8'h00;
        pf_pu_ov  = port_ef_alt_pkg::PF_JTAG_MASK;
        pf_dd_oe  = pf_pu_oe;
        pf_dd_ov  = 8'h00;
        pf_die_oe = pf_pu_oe;
        pf_die_ov = 8'h00;
        pf_pv_oe  = 8'h00;
        pf_pv_ov  = 8'h00;
        // [RULE_13] TDO drives only while shifting
        pf_dd_ov[port_ef_alt_pkg::PF_TDO] = tdo_drive;
        pf_pv_oe[port_ef_alt_pkg::PF_TDO] = i_jtag_enable;
        pf_pv_ov[port_ef_alt_pkg::PF_TDO] = i_tap_tdo;
    end

    // Resolve each pin against the normal port logic
    always_comb begin
        // [RULE_17] override or normal value
        pe_dir_f = pick(pe_dd_oe, pe_dd_ov, i_pe_dir);
        pf_dir_f = pick(pf_dd_oe, pf_dd_ov, i_pf_dir);
        pe_die_f = pick(pe_die_oe, pe_die_ov, ~{8{i_sleep_input_disable}});
        pf_die_f = pick(pf_die_oe, pf_die_ov, ~{8{i_sleep_input_disable}});
        next_pe_drive_n = ~pe_dir_f;
        next_pf_drive_n = ~pf_dir_f;
        next_pe_out = pick(pe_pv_oe, pe_pv_ov, i_pe_port);
        next_pf_out = pick(pf_pv_oe, pf_pv_ov, i_pf_port);
        // Pull-up only on a released pin
        next_pe_pullup = ~pe_dir_f & pick(pe_pu_oe, pe_pu_ov,
            i_pe_port & ~i_pe_dir & ~{8{i_global_pullup_disable}});
        next_pf_pullup = ~pf_dir_f & pick(pf_pu_oe, pf_pu_ov,
            i_pf_port & ~i_pf_dir & ~{8{i_global_pullup_disable}});
        // Disabled inputs read as zero to stop floating-pin current
        next_pe_din = pe_sync & pe_die_f;
        next_pf_din = pf_sync & pf_die_f;
        // [RULE_04] clock toggle strobe
        next_pe_toggle = i_serial_two_wire_mode
            & i_serial_clock_toggle_strobe;
        // [RULE_09] receiver shares pin-change input
        next_receive_data = pe_sync[port_ef_alt_pkg::PE_RXD];
        next_serial_data_in = pe_sync[port_ef_alt_pkg::PE_SDA];
        next_serial_clock_in = pe_sync[port_ef_alt_pkg::PE_SCL];
        // [RULE_07] clock input only in sync mode
        next_usart_clock_in = i_usart_sync_mode
            & ~i_pe_dir[port_ef_alt_pkg::PE_XCK]
            & pe_sync[port_ef_alt_pkg::PE_XCK];
        // [RULE_15] TAP clocks on these, not here
        next_jtag_tdi = i_jtag_enable & pf_sync[port_ef_alt_pkg::PF_TDI];
        next_jtag_tms = i_jtag_enable & pf_sync[port_ef_alt_pkg::PF_TMS];
        next_jtag_tck = i_jtag_enable & pf_sync[port_ef_alt_pkg::PF_TCK];
        if (i_rst) begin
            next_pe_drive_n = port_ef_alt_pkg::RST_DRIVE_N;
            next_pe_out     = port_ef_alt_pkg::RST_OUT;
            next_pe_pullup  = port_ef_alt_pkg::RST_PULLUP;
            next_pe_din     = port_ef_alt_pkg::RST_DIN;
            next_pe_toggle  = port_ef_alt_pkg::RST_BIT;
            next_pf_drive_n = port_ef_alt_pkg::RST_DRIVE_N;
            next_pf_out     = port_ef_alt_pkg::RST_OUT;
            next_pf_din     = port_ef_alt_pkg::RST_DIN;
            // [RULE_01] clock stays out through reset
            next_pe_drive_n[port_ef_alt_pkg::PE_CLKO] = ~i_clock_output_fuse;
            next_pe_out[port_ef_alt_pkg::PE_CLKO] =
                i_clock_output_fuse & i_io_clk_div;
            // [RULE_11] test pull-ups survive reset
            next_pf_pullup = i_jtag_enable
                ? port_ef_alt_pkg::PF_JTAG_PU_MASK
                : port_ef_alt_pkg::RST_PULLUP;
            next_receive_data    = port_ef_alt_pkg::RST_BIT;
            next_serial_data_in  = port_ef_alt_pkg::RST_BIT;
            next_serial_clock_in = port_ef_alt_pkg::RST_BIT;
            next_usart_clock_in  = port_ef_alt_pkg::RST_BIT;
            next_jtag_tdi        = port_ef_alt_pkg::RST_BIT;
            next_jtag_tms        = port_ef_alt_pkg::RST_BIT;
            next_jtag_tck        = port_ef_alt_pkg::RST_BIT;
        end
    end

    // Output registers; reset values arrive through the next_ logic
    always_ff @(posedge i_core_clk) begin
        o_pe_drive_n      <= next_pe_drive_n;
        o_pe_out          <= next_pe_out;
        o_pe_pullup       <= next_pe_pullup;
        o_pe_din          <= next_pe_din;
        o_pe_toggle       <= next_pe_toggle;
        o_pf_drive_n      <= next_pf_drive_n;
        o_pf_out          <= next_pf_out;
        o_pf_pullup       <= next_pf_pullup;
        o_pf_din          <= next_pf_din;
        o_receive_data    <= next_receive_data;
        o_serial_data_in  <= next_serial_data_in;
        o_serial_clock_in <= next_serial_clock_in;
        o_usart_clock_in  <= next_usart_clock_in;
        o_jtag_tdi        <= next_jtag_tdi;
        o_jtag_tms        <= next_jtag_tms;
        o_jtag_tck        <= next_jtag_tck;
    end

endmodule

// *** port_pad_model.sv ***
// Pad model: the block, outside drivers and pull-ups resolve each pin
`timescale 1ns/1ps
module port_pad_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_drive_n,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_pullup,
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    output logic      [7:0] o_pin
);
    logic float_lvl = 1'b0;

    // A floating pin wanders, so a stale level is never trusted
    always @(posedge i_core_clk) float_lvl <= ~float_lvl;

    // Block wins over outside drivers; outside wins over the pull-up
    // outside levels only move on core edges
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (!i_drive_n[b]) o_pin[b] = i_out[b];
            else if (i_ext_en[b]) o_pin[b] = i_ext_val[b];
            else if (i_pullup[b]) o_pin[b] = 1'b1;
            else o_pin[b] = float_lvl;
        end
    end
endmodule

// *** port_e_f_alt_function_override_props.sv ***
// Concurrent checks on the port E/F override outputs
`timescale 1ns/1ps
module port_ef_alt_checker (
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    input wire logic [7:0] i_pe_port,
    input wire logic [7:0] i_pe_dir,
    input wire logic       i_global_pullup_disable,
    input wire logic       i_clock_output_fuse,
    input wire logic       i_io_clk_div,
    input wire logic       i_serial_two_wire_mode,
    input wire logic       i_serial_three_wire_mode,
    input wire logic       i_serial_data_out,
    input wire logic       i_serial_clock_hold,
    input wire logic       i_serial_clock_toggle_strobe,
    input wire logic       i_transmitter_enable,
    input wire logic       i_transmit_data,
    input wire logic       i_receiver_enable,
    input wire logic       i_jtag_enable,
    input wire logic       i_tap_shift_ir,
    input wire logic       i_tap_shift_dr,
    input wire logic       i_tap_tdo,
    input wire logic [7:0] o_pe_drive_n,
    input wire logic [7:0] o_pe_out,
    input wire logic [7:0] o_pe_pullup,
    input wire logic       o_pe_toggle,
    input wire logic [7:0] o_pf_drive_n,
    input wire logic [7:0] o_pf_out,
    input wire logic [7:0] o_pf_pullup
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // Toggle request and its one-cycle-late pulse
    sequence toggle_req_s;
        i_serial_two_wire_mode && i_serial_clock_toggle_strobe;
    endsequence
    // The pulse follows the gated request, so a mode drop ends it too
    sequence toggle_out_s;
        ##1 o_pe_toggle
        ##1 (o_pe_toggle == ($past(i_serial_two_wire_mode)
            && $past(i_serial_clock_toggle_strobe)));
    endsequence

    a_clko_drive: assert property (i_clock_output_fuse |=> !o_pe_drive_n[7]
        && o_pe_out[7] == $past(i_io_clk_div)) else $error("clock out pin wrong");
    a_three_wire_data: assert property (i_serial_three_wire_mode && i_pe_dir[6]
        |=> o_pe_out[6] == $past(i_serial_data_out)) else $error("data out wrong");
    a_sda_override: assert property (i_serial_two_wire_mode |=> !o_pe_pullup[5]
        && o_pe_drive_n[5] == !(($past(i_serial_data_out) || $past(i_pe_port[5]))
        && $past(i_pe_dir[5]))) else $error("data pin override wrong");
    a_scl_override: assert property (i_serial_two_wire_mode |=> !o_pe_pullup[4]
        && o_pe_drive_n[4] == !(($past(i_serial_clock_hold) && $past(i_pe_port[4]))
        || $past(i_pe_dir[4]))) else $error("clock pin override wrong");
    a_toggle_pulse: assert property (toggle_req_s |-> toggle_out_s)
        else $error("toggle pulse wrong");
    a_tx_output: assert property (i_transmitter_enable |=> !o_pe_drive_n[1]
        && !o_pe_pullup[1] && o_pe_out[1] == $past(i_transmit_data))
        else $error("transmit pin wrong");
    a_rx_input: assert property (i_receiver_enable |=> o_pe_drive_n[0]
        && o_pe_pullup[0] == ($past(i_pe_port[0]) && !$past(i_global_pullup_disable)))
        else $error("receive pin wrong");
    a_tdo_shift: assert property (i_jtag_enable && (i_tap_shift_ir || i_tap_shift_dr)
        |=> !o_pf_drive_n[6] && o_pf_out[6] == $past(i_tap_tdo)) else $error("tdo idle");
    a_tap_released: assert property (i_jtag_enable && !i_tap_shift_ir && !i_tap_shift_dr
        |=> o_pf_drive_n[7:4] == 4'hF && o_pf_pullup[7:4] == 4'hF)
        else $error("test pins not released");
    a_jtag_reset_pullup: assert property (disable iff (1'b0) i_rst && i_jtag_enable
        |=> (o_pf_pullup & 8'hB0) == 8'hB0) else $error("reset pull-ups off");
endmodule

bind port_e_f_alt_function_override port_ef_alt_checker u_chk (.*);

// *** test_port_e_f_alt_function_override.sv ***
// Self-checking bench for the port E/F override block
`timescale 1ns/1ps
module test_port_e_f_alt_function_override;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_pe_port, i_pe_dir, i_pf_port, i_pf_dir, i_pin_change_mask;
    logic [7:0] i_pe_pin, i_pf_pin, ee_en, ee_val, ef_en, ef_val;
    logic i_clock_output_fuse, i_io_clk_div, i_jtag_enable, i_tap_tdo;
    logic i_serial_two_wire_mode, i_serial_clock_toggle_strobe, i_usart_clock;
    logic i_global_pullup_disable, i_sleep_input_disable, i_serial_data_out;
    logic i_serial_three_wire_mode, i_serial_clock_hold, i_usart_sync_mode;
    logic i_start_condition_irq_enable, i_pin_change_group_enable;
    logic i_comparator_pos_digital_disable, i_comparator_neg_digital_disable;
    logic i_transmitter_enable, i_transmit_data, i_receiver_enable;
    logic i_tap_shift_ir, i_tap_shift_dr, o_pe_toggle, o_receive_data;
    logic o_serial_data_in, o_serial_clock_in, o_usart_clock_in;
    logic o_jtag_tdi, o_jtag_tms, o_jtag_tck;
    logic [7:0] o_pe_drive_n, o_pe_out, o_pe_pullup, o_pe_din;
    logic [7:0] o_pf_drive_n, o_pf_out, o_pf_pullup, o_pf_din;
    logic [7:0] ed_e, eo_e, ep_e, ie_e, ed_f, eo_f, ep_f, ie_f;
    int error_cnt = 0;
    int n_tests = 0;

    always #12.5 i_core_clk = ~i_core_clk;

    port_e_f_alt_function_override DUT (.*);
    port_pad_model pad_e (.i_core_clk(i_core_clk), .i_drive_n(o_pe_drive_n),
        .i_out(o_pe_out), .i_pullup(o_pe_pullup), .i_ext_en(ee_en),
        .i_ext_val(ee_val), .o_pin(i_pe_pin));
    port_pad_model pad_f (.i_core_clk(i_core_clk), .i_drive_n(o_pf_drive_n),
        .i_out(o_pf_out), .i_pullup(o_pf_pullup), .i_ext_en(ef_en),
        .i_ext_val(ef_val), .o_pin(i_pf_pin));

    // Top five bits are the ones directed tests need by position
    task automatic set_ctl(input logic [21:0] v);
        {i_clock_output_fuse, i_io_clk_div, i_jtag_enable,
         i_serial_two_wire_mode, i_serial_clock_toggle_strobe,
         i_global_pullup_disable, i_sleep_input_disable,
         i_serial_three_wire_mode, i_serial_data_out, i_serial_clock_hold,
         i_start_condition_irq_enable, i_pin_change_group_enable,
         i_comparator_pos_digital_disable, i_comparator_neg_digital_disable,
         i_usart_sync_mode, i_usart_clock, i_transmitter_enable,
         i_transmit_data, i_receiver_enable, i_tap_shift_ir, i_tap_shift_dr,
         i_tap_tdo} = v;
    endtask

    // Masked bits are those whose level nobody defines
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input logic [7:0] msk);
        n_tests++;
        if ((got & msk) !== (exp & msk)) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
        end
    endtask

    // Reference model of every override, then compare all outputs
    task automatic check_all();
        logic [7:0] mg, pe, pf, ke, kf;
        mg = i_pin_change_mask & {8{i_pin_change_group_enable}};
        ed_e = i_pe_dir;
        eo_e = i_pe_port;
        ep_e = i_pe_port & ~i_pe_dir & {8{~i_global_pullup_disable}};
        ie_e = {8{~i_sleep_input_disable}} | (mg & 8'hF3);
        ie_e[5:4] = ie_e[5:4] | {2{i_start_condition_irq_enable}};
        if (mg[3] | i_comparator_neg_digital_disable) ie_e[3] = mg[3];
        if (mg[2] | i_comparator_pos_digital_disable) ie_e[2] = mg[2];
        if (i_clock_output_fuse) {ed_e[7], eo_e[7]} = {1'b1, i_io_clk_div};
        if (i_serial_three_wire_mode) eo_e[6] = i_serial_data_out;
        if (i_serial_two_wire_mode) begin
            ep_e[5:4] = 2'b00;
            ed_e[5] = (i_serial_data_out | i_pe_port[5]) & i_pe_dir[5];
            ed_e[4] = (i_serial_clock_hold & i_pe_port[4]) | i_pe_dir[4];
            eo_e[5:4] = eo_e[5:4] & ~i_pe_dir[5:4];
        end
        if (i_usart_sync_mode & i_pe_dir[2]) eo_e[2] = i_usart_clock;
        if (i_transmitter_enable) {ep_e[1], ed_e[1]} = 2'b01;
        if (i_transmitter_enable) eo_e[1] = i_transmit_data;
        if (i_receiver_enable) ed_e[0] = 1'b0;
        if (i_receiver_enable) ep_e[0] = i_pe_port[0] & ~i_global_pullup_disable;
        ed_f = i_pf_dir;
        eo_f = i_pf_port;
        ep_f = i_pf_port & ~i_pf_dir & {8{~i_global_pullup_disable}};
        ie_f = {8{~i_sleep_input_disable}};
        if (i_jtag_enable) begin
            ed_f[7:4] = {1'b0, i_tap_shift_ir | i_tap_shift_dr, 2'b00};
            eo_f[6] = i_tap_tdo;
            {ep_f[7:4], ie_f[7:4]} = 8'hF0;
        end
        ep_e = ep_e & ~ed_e;
        ep_f = ep_f & ~ed_f;
        ke = ed_e | ee_en | ep_e;
        kf = ed_f | ef_en | ep_f;
        pe = (ed_e & eo_e) | (~ed_e & ((ee_en & ee_val) | (~ee_en & ep_e)));
        pf = (ed_f & eo_f) | (~ed_f & ((ef_en & ef_val) | (~ef_en & ep_f)));
        chk(o_pe_drive_n, ~ed_e, 8'hFF);
        chk(o_pe_out, eo_e, ed_e);
        chk(o_pe_pullup, ep_e, 8'hFF);
        chk(o_pe_din, pe & ie_e, ke | ~ie_e);
        chk(o_pf_drive_n, ~ed_f, 8'hFF);
        chk(o_pf_out, eo_f, ed_f);
        chk(o_pf_pullup, ep_f, 8'hFF);
        chk(o_pf_din, pf & ie_f, kf | ~ie_f);
        chk({o_pe_toggle, o_jtag_tdi, o_jtag_tms, o_jtag_tck, o_usart_clock_in,
             o_serial_clock_in, o_serial_data_in, o_receive_data},
            {i_serial_two_wire_mode & i_serial_clock_toggle_strobe,
             pf[7] & i_jtag_enable, pf[5] & i_jtag_enable, pf[4] & i_jtag_enable,
             pe[2] & i_usart_sync_mode & ~i_pe_dir[2], pe[4], pe[5], pe[0]},
            {1'b1, kf[7] | ~i_jtag_enable, kf[5] | ~i_jtag_enable,
             kf[4] | ~i_jtag_enable, ke[2] | ~i_usart_sync_mode | i_pe_dir[2],
             ke[4], ke[5], ke[0]});
    endtask

    // Prints the counts and the verdict, then stops
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Main sequence: reset, toggle pulse, then random configurations
    initial begin
        void'($urandom(98));
        {i_pe_port, i_pe_dir, i_pf_port, i_pf_dir} = 32'h0;
        {i_pin_change_mask, ee_en, ee_val, ef_en} = 32'h0;
        ef_val = 8'h00;
        set_ctl(22'h380000);
        repeat (4) @(negedge i_core_clk);
        chk(o_pe_drive_n, 8'h7F, 8'hFF);
        chk(o_pe_out, 8'h80, 8'hFF);
        chk(o_pf_pullup, 8'hB0, 8'hFF);
        $display("reset test done");
        i_rst = 1'b0;
        set_ctl(22'h060000);
        @(negedge i_core_clk);
        set_ctl(22'h040000);
        chk({7'h00, o_pe_toggle}, 8'h01, 8'h01);
        @(negedge i_core_clk);
        chk({7'h00, o_pe_toggle}, 8'h00, 8'h01);
        $display("toggle test done");
        // Pads settle through the synchroniser before each compare
        repeat (120) begin
            @(negedge i_core_clk);
            set_ctl(22'($urandom));
            {i_pe_port, i_pe_dir, i_pf_port, i_pf_dir} = $urandom;
            {i_pin_change_mask, ee_en, ee_val, ef_en} = $urandom;
            ef_val = 8'($urandom);
            repeat (6) @(negedge i_core_clk);
            check_all();
        end
        $display("random test done");
        results();
    end

    // Watchdog well beyond the roughly 846 cycles the tests need
    initial begin
        #(25 * 2000);
        error_cnt++;
        results();
    end
endmodule
